// ---- logic/osj_pkg.sv ----
// Constants, encodings and carrier types of the OTP security and JTAG identification block
// Assumes: imported by the one design module of this block and by the bench
package osj_pkg;
    localparam int          OTP_ROWS      = 2048;
    localparam int          SECTOR_ROWS   = 512;
    localparam int          ROW_W         = 32;
    localparam int          ADDR_W        = 11;
    localparam int          MEM_AW        = 12;
    localparam logic [11:0] SEC_ROW       = 12'h800;
    localparam int          SEC_JTAG_OFF  = 0;
    localparam int          SEC_LINK_OFF  = 1;
    localparam int          SEC_BOOT_OTP  = 5;
    localparam int          SEC_REDUND    = 7;
    localparam int          SEC_LOCK_LO   = 8;
    localparam int          SEC_MASTER    = 12;
    localparam int          SEC_JTAG_OTP  = 13;
    localparam int          SEC_GP_LO     = 15;
    localparam int          SEC_GP_W      = 7;
    localparam int          SEC_UID_LO    = 22;
    localparam int          SEC_UID_W     = 10;
    localparam logic [31:0] SEC_USED_MASK = 32'hFFFFBFA3;
    localparam logic [31:0] SEC_RESET     = 32'h00000000;
    localparam logic [23:0] RES_OTP_ADDR  = 24'h100200;
    localparam logic [23:0] RES_OTP_DATA  = 24'h200100;
    localparam logic [23:0] RES_OTP_CTRL  = 24'h100300;
    localparam int          CTRL_PROG_ROW = 0;
    localparam int          CTRL_PROG_SEC = 1;
    localparam logic [3:0]  IR_DEVICE_IDENTIFICATION     = 4'h1;
    localparam logic [3:0]  IR_USERCODE   = 4'h2;
    localparam logic [3:0]  IR_OTP_ADDR   = 4'h8;
    localparam logic [3:0]  IR_OTP_READ   = 4'h9;
    localparam logic [3:0]  IR_OTP_WRITE  = 4'hA;
    localparam logic [3:0]  IR_CAPTURE    = 4'h1;
    localparam logic [2:0]  TMS_RESET_CNT = 3'h5;
    localparam int          USR_UNUSED_W  = 4;
    localparam int          USR_REV_W     = 18;

    typedef enum logic [3:0] {
        TAP_RESET  = 4'h0, TAP_IDLE   = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
        TAP_SH_DR  = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR  = 4'h6, TAP_EX2_DR = 4'h7,
        TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SH_IR  = 4'hB,
        TAP_EX1_IR = 4'hC, TAP_PA_IR  = 4'hD, TAP_EX2_IR = 4'hE, TAP_UPD_IR = 4'hF
    } osj_tap_type;

    typedef enum logic [1:0] {
        BOOT_LOAD = 2'b00,
        BOOT_COPY = 2'b01,
        BOOT_RUN  = 2'b10
    } osj_boot_type;

    typedef struct packed {
        logic        wr;
        logic [23:0] res_id;
        logic [31:0] data;
    } osj_prog_type;

    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [ROW_W-1:0]  data;
    } osj_sram_type;
endpackage

// ---- logic/osj_top.sv ----
// OTP store with power-up security word, processor programming ports and a two-TAP JTAG chain
// Assumes: one 25 MHz clock; JTAG pins are asynchronous and oversampled; SRAM takes one word a cycle
// What this block does
// - Store holds four sectors of 512 rows, 32 bits each, 8 KB.
// - Security word is loaded from the store at power up before features act.
// - Remaining store content is copied to SRAM before the core is released.
// - Security bit 0 turns off JTAG access to tile state and memory.
// - Security bit 1 denies other tiles switch access to this processor.
// - Security bit 5 makes the core boot from store address zero.
// - Security bit 7 enables the redundant rows of the store.
// - Security bits 8 to 11 each lock programming of one sector.
// - Security bit 12 locks all programming, sectors and security word alike.
// - Security bit 13 blocks JTAG reads and writes of the store.
// - Security bits 15 to 21 are a general field visible to software.
// - Security bits 22 to 31 hold the user identification extension.
// - Programming uses address, data and control ports at fixed resource codes.
// - After reset the chain holds a boundary-scan TAP and a chip TAP.
// - Five test clocks with TMS high return the JTAG logic to reset.
// - DEVICE_IDENTIFICATION instruction returns the 32-bit device identification code.
// - USERCODE returns user field on top, unused field, then silicon revision.
// - User field of the user code comes from security bits 22 to 31.
// - With secure boot clear the core boots from internal flash.
`timescale 1ns/1ps
`default_nettype none
module osj_top #(
    parameter logic [31:0]  CHIP_DEVICE_IDENTIFICATION  = 32'h0ABC_D001, // arbitrary value
    parameter logic [31:0]  BSCAN_DEVICE_IDENTIFICATION = 32'h0ABC_E001, // arbitrary value
    parameter logic [17:0]  SILICON_REV  = 18'h00001      // arbitrary value
) (
    // Clock and reset
    input  wire logic            clock,
    input  wire logic            sys_rst,
    // Processor programming ports
    input  wire osj_pkg::osj_prog_type prog_req,
    output var  logic            prog_done,
    output var  logic            prog_refused,
    // SRAM fill and boot control
    output var  osj_pkg::osj_sram_type sram_wr,
    output var  logic            core_release,
    output var  logic            boot_from_otp,
    // Security features
    output var  logic [31:0]     security_config,
    output var  logic [6:0]      gp_field,
    output var  logic            link_access_deny,
    output var  logic            redundant_rows_en,
    output var  logic            jtag_tile_access_en,
    // JTAG pins
    input  wire logic            tck,
    input  wire logic            tms,
    input  wire logic            tdi,
    output var  logic            tdo,
    output var  logic            tdo_oe
);
    import osj_pkg::*;

    logic [ROW_W-1:0]  otp_mem [OTP_ROWS+1] = '{default: '0};
    osj_boot_type      boot_state;
    logic [ADDR_W-1:0] copy_addr;
    logic [31:0]       security_r;
    logic [15:0]       prog_addr_r;
    logic [31:0]       prog_data_r;
    logic              ctrl_wr, row_ok, sec_ok, cpu_row_wr, cpu_sec_wr, jtag_row_wr, jtag_otp_ok;
    logic [3:0]        lock_bits;
    logic [2:0]        tck_sy, tms_sy, tdi_sy;
    logic              tck_lvl_r, tck_rise, tck_fall;
    logic [2:0]        tms_cnt;
    osj_tap_type       tap_state;
    logic [3:0]        ir_r  [2];
    logic [3:0]        ir_sh [2];
    logic [31:0]       dr_sh [2];
    logic [31:0]       cap   [2];
    logic              sin   [2];
    logic              so    [2];
    logic              byp   [2];
    logic [ADDR_W-1:0] jtag_addr_r;

    function automatic osj_tap_type tap_next(input osj_tap_type s, input logic m);
        case (s)
            TAP_RESET:  tap_next = m ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR:  tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = m ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR:  tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            default:    tap_next = TAP_RESET;
        endcase
    endfunction

    // Programming ports decoded by resource code
    assign ctrl_wr     = prog_req.wr && (prog_req.res_id == RES_OTP_CTRL);
    assign lock_bits   = security_r[SEC_LOCK_LO +: 4];
    assign row_ok      = core_release && !security_r[SEC_MASTER] && (prog_addr_r[15:ADDR_W] == '0)
                         && !lock_bits[prog_addr_r[ADDR_W-1:ADDR_W-2]];
    assign sec_ok      = core_release && !security_r[SEC_MASTER];
    assign cpu_row_wr  = ctrl_wr && prog_req.data[CTRL_PROG_ROW] && row_ok;
    assign cpu_sec_wr  = ctrl_wr && prog_req.data[CTRL_PROG_SEC] && sec_ok;
    assign jtag_otp_ok = core_release && !security_r[SEC_JTAG_OFF] && !security_r[SEC_JTAG_OTP];
    assign jtag_row_wr = tck_rise && (tap_state == TAP_UPD_DR) && (ir_r[1] == IR_OTP_WRITE) && jtag_otp_ok
                         && !security_r[SEC_MASTER] && !lock_bits[jtag_addr_r[ADDR_W-1:ADDR_W-2]];

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            prog_addr_r <= '0;
            prog_data_r <= '0;
        end
        else if (prog_req.wr && (prog_req.res_id == RES_OTP_ADDR))
            prog_addr_r <= prog_req.data[15:0];
        else if (prog_req.wr && (prog_req.res_id == RES_OTP_DATA))
            prog_data_r <= prog_req.data;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            prog_done    <= 1'b0;
            prog_refused <= 1'b0;
        end
        else
        begin
            prog_done    <= cpu_row_wr || cpu_sec_wr;
            prog_refused <= ctrl_wr && ((prog_req.data[CTRL_PROG_ROW] && !row_ok) ||
                                        (prog_req.data[CTRL_PROG_SEC] && !sec_ok));
        end
    end

    // Fuses only ever gain set bits
    always_ff @(posedge clock)
    begin
        if (cpu_row_wr)
            otp_mem[{1'b0, prog_addr_r[ADDR_W-1:0]}] <= otp_mem[{1'b0, prog_addr_r[ADDR_W-1:0]}] | prog_data_r;
        else if (cpu_sec_wr)
            otp_mem[SEC_ROW] <= otp_mem[SEC_ROW] | prog_data_r;
        else if (jtag_row_wr)
            otp_mem[{1'b0, jtag_addr_r}] <= otp_mem[{1'b0, jtag_addr_r}] | dr_sh[1];
    end

    // Power-up load of the security word, then copy of the store into SRAM
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            boot_state   <= BOOT_LOAD;
            copy_addr    <= '0;
            security_r   <= SEC_RESET;
            sram_wr      <= '0;
            core_release <= 1'b0;
        end
        else
            case (boot_state)
                BOOT_LOAD:
                begin
                    security_r <= otp_mem[SEC_ROW] & SEC_USED_MASK;
                    boot_state <= BOOT_COPY;
                end
                BOOT_COPY:
                begin
                    sram_wr   <= '{we: 1'b1, addr: copy_addr, data: otp_mem[{1'b0, copy_addr}]};
                    copy_addr <= copy_addr + 1'b1;
                    if (&copy_addr)
                        boot_state <= BOOT_RUN;
                end
                BOOT_RUN:
                begin
                    sram_wr.we   <= 1'b0;
                    core_release <= 1'b1;
                end
                default: boot_state <= BOOT_LOAD;
            endcase
    end

    // Feature outputs follow the loaded word once it is valid
    always_ff @(posedge clock)
    begin
        if (sys_rst || (boot_state == BOOT_LOAD))
        begin
            security_config     <= '0;
            gp_field            <= '0;
            link_access_deny    <= 1'b1;
            redundant_rows_en   <= 1'b0;
            jtag_tile_access_en <= 1'b0;
            boot_from_otp       <= 1'b0;
        end
        else
        begin
            security_config     <= security_r;
            gp_field            <= security_r[SEC_GP_LO +: SEC_GP_W];
            link_access_deny    <= security_r[SEC_LINK_OFF];
            redundant_rows_en   <= security_r[SEC_REDUND];
            jtag_tile_access_en <= !security_r[SEC_JTAG_OFF];
            boot_from_otp       <= security_r[SEC_BOOT_OTP];
        end
    end

    // JTAG pins: three-stage synchronisers, edge once stages two and three agree
    // Level tracks the pin in reset, so a test clock parked high gives no false edge
    always_ff @(posedge clock)
    begin
        tck_sy <= {tck_sy[1:0], tck};
        tms_sy <= {tms_sy[1:0], tms};
        tdi_sy <= {tdi_sy[1:0], tdi};
        if (sys_rst || (tck_sy[1] == tck_sy[2]))
            tck_lvl_r <= tck_sy[2];
    end
    assign tck_rise = (tck_sy[1] == tck_sy[2]) && tck_sy[2] && !tck_lvl_r;
    assign tck_fall = (tck_sy[1] == tck_sy[2]) && !tck_sy[2] && tck_lvl_r;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            tms_cnt <= '0;
        else if (tck_rise)
            tms_cnt <= !tms_sy[2] ? 3'h0 : (tms_cnt == TMS_RESET_CNT) ? tms_cnt : tms_cnt + 3'h1;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            tap_state <= TAP_RESET;
        else if (tck_rise)
            tap_state <= (tms_sy[2] && (tms_cnt >= TMS_RESET_CNT - 3'h1)) ? TAP_RESET
                                                                          : tap_next(tap_state, tms_sy[2]);
    end

    // Chain order: tdi, boundary-scan TAP (0), chip TAP (1), tdo
    always_comb
    begin
        sin[0] = tdi_sy[2];
        for (int t = 0; t < 2; t++)
            so[t] = (tap_state == TAP_SH_IR) ? ir_sh[t][0] : dr_sh[t][0];
        sin[1] = so[0];
        byp[0] = (ir_r[0] != IR_DEVICE_IDENTIFICATION);
        byp[1] = !((ir_r[1] == IR_DEVICE_IDENTIFICATION) || (ir_r[1] == IR_USERCODE) || (ir_r[1] == IR_OTP_ADDR) ||
                   (ir_r[1] == IR_OTP_READ) || (ir_r[1] == IR_OTP_WRITE));
        cap[0] = byp[0] ? 32'h0 : BSCAN_DEVICE_IDENTIFICATION;
        case (ir_r[1])
            IR_DEVICE_IDENTIFICATION:   cap[1] = CHIP_DEVICE_IDENTIFICATION;
            IR_USERCODE: cap[1] = {security_r[SEC_UID_LO +: SEC_UID_W],
                                   {USR_UNUSED_W{1'b0}}, SILICON_REV};
            IR_OTP_ADDR: cap[1] = {21'h0, jtag_addr_r};
            IR_OTP_READ: cap[1] = jtag_otp_ok ? otp_mem[{1'b0, jtag_addr_r}] : 32'h0;
            default:     cap[1] = 32'h0;
        endcase
    end

    // Both TAPs share the state machine and are present from reset
    always_ff @(posedge clock)
    begin
        for (int t = 0; t < 2; t++)
        begin
            if (sys_rst)
            begin
                ir_r[t]  <= IR_DEVICE_IDENTIFICATION;
                ir_sh[t] <= '0;
                dr_sh[t] <= '0;
            end
            else if (tck_rise)
                case (tap_state)
                    TAP_RESET:  ir_r[t]  <= IR_DEVICE_IDENTIFICATION;
                    TAP_CAP_IR: ir_sh[t] <= IR_CAPTURE;
                    TAP_SH_IR:  ir_sh[t] <= {sin[t], ir_sh[t][3:1]};
                    TAP_UPD_IR: ir_r[t]  <= ir_sh[t];
                    TAP_CAP_DR: dr_sh[t] <= cap[t];
                    TAP_SH_DR:  dr_sh[t] <= byp[t] ? {31'h0, sin[t]} : {sin[t], dr_sh[t][31:1]};
                    default:    ;
                endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            jtag_addr_r <= '0;
        else if (tck_rise && (tap_state == TAP_UPD_DR) && (ir_r[1] == IR_OTP_ADDR) && jtag_otp_ok)
            jtag_addr_r <= dr_sh[1][ADDR_W-1:0];
    end

    // Data out changes on the falling test clock
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else if (tck_fall)
        begin
            tdo    <= so[1];
            tdo_oe <= (tap_state == TAP_SH_DR) || (tap_state == TAP_SH_IR);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sec_load_a: assert property (((boot_state == BOOT_LOAD) && !sys_rst) |=>
        (security_r == ($past(otp_mem[SEC_ROW]) & SEC_USED_MASK)))
        else $error("security word not loaded");
    release_after_copy_a: assert property ($rose(core_release) |->
        ($past(boot_state, 2) == BOOT_COPY) && (copy_addr == '0))
        else $error("core released before copy ended");
    link_deny_a: assert property (core_release |-> (link_access_deny == security_r[SEC_LINK_OFF]))
        else $error("link deny does not follow security bit");
    boot_source_a: assert property (core_release |-> (boot_from_otp == security_r[SEC_BOOT_OTP]))
        else $error("boot source does not follow security bit");
    sector_lock_a: assert property (ctrl_wr && prog_req.data[CTRL_PROG_ROW] &&
        lock_bits[prog_addr_r[10:9]] |=> prog_refused && !prog_done)
        else $error("locked sector programmed");
    master_lock_a: assert property ((ctrl_wr && security_r[SEC_MASTER]) |=>
        $stable(otp_mem[SEC_ROW]) && (prog_refused == $past(prog_req.data[1] || prog_req.data[0])))
        else $error("master lock ignored");
    jtag_otp_block_a: assert property ((security_r[SEC_JTAG_OTP] && core_release) |-> !jtag_row_wr)
        else $error("jtag reached store while blocked");
    tms_reset_a: assert property ((tck_rise && tms_sy[2] && (tms_cnt == TMS_RESET_CNT - 3'h1)) |=>
        (tap_state == TAP_RESET))
        else $error("five tms highs did not reset tap");
    usercode_a: assert property ((tck_rise && (tap_state == TAP_CAP_DR) && (ir_r[1] == IR_USERCODE)) |=>
        (dr_sh[1][31:22] == security_r[31:22]))
        else $error("user field not from security word");
    reserved_zero_a: assert property ((security_r & ~SEC_USED_MASK) == 32'h0)
        else $error("reserved security bits set");
endmodule
`default_nettype wire

// ---- test/osj_host.sv ----
// Test host for the JTAG pins of the OTP security block
// Assumes: driven from the bench by hierarchical task calls; clock is the 25 MHz system clock
`timescale 1ns/1ps
`default_nettype none
module osj_host (
    // System clock used to pace the test clock
    input  wire logic clock,
    // JTAG pins
    output var  logic tck,
    output var  logic tms,
    output var  logic tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    // Shift steps that saw tdo enabled during the latest scan
    int oe_hits;

    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One test clock: 9 clocks low, 9 high; tdo taken just before the rise
    task automatic step(input logic m, input logic d, output logic q);
        @(posedge clock);
        tms <= m;
        tdi <= d;
        tck <= 1'b0;
        repeat (8) @(posedge clock);
        #1 q = tdo;
        if (tdo_oe === 1'b1)
            oe_hits++;
        @(posedge clock);
        tck <= 1'b1;
        repeat (8) @(posedge clock);
    endtask

    // Five highs on TMS, then one low to park in Run-Test/Idle
    task automatic reset_tap;
        logic q;
        repeat (5) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask

    // IR or DR scan from idle back to idle, LSB first
    task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
        logic q;
        dout = '0;
        oe_hits = 0;
        step(1'b1, ~tdi, q);
        if (ir)
            step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the OTP security and JTAG identification block
// Assumes: osj_pkg and osj_top compiled first; osj_host stands in for the JTAG host
`timescale 1ns/1ps
`default_nettype none
module tb;
    import osj_pkg::*;
    localparam logic [31:0] CHIP_ID  = 32'h0123_4567; // arbitrary value
    localparam logic [31:0] BSCAN_ID = 32'h0765_4321; // arbitrary value
    localparam logic [17:0] REV      = 18'h0002A;     // arbitrary value
    localparam logic [31:0] SEC_A    = 32'hA940_0200;

    logic         clock, sys_rst, prog_done, prog_refused, core_release, boot_from_otp;
    logic         link_access_deny, redundant_rows_en, jtag_tile_access_en;
    logic         tck, tms, tdi, tdo, tdo_oe;
    logic [31:0]  security_config;
    logic [6:0]   gp_field;
    logic [63:0]  d;
    osj_prog_type prog_req;
    osj_sram_type sram_wr;
    int           miscompares, check_count, copies;
    logic [31:0]  seen [0:2047];

    osj_top #(.CHIP_DEVICE_IDENTIFICATION(CHIP_ID), .BSCAN_DEVICE_IDENTIFICATION(BSCAN_ID), .SILICON_REV(REV)) dut_u (
        .clock(clock), .sys_rst(sys_rst), .prog_req(prog_req), .prog_done(prog_done),
        .prog_refused(prog_refused), .sram_wr(sram_wr), .core_release(core_release),
        .boot_from_otp(boot_from_otp), .security_config(security_config), .gp_field(gp_field),
        .link_access_deny(link_access_deny), .redundant_rows_en(redundant_rows_en),
        .jtag_tile_access_en(jtag_tile_access_en), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
    osj_host host_u (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

    initial clock = 1'b0;
    always #20 clock = ~clock;
    initial
    begin
        sys_rst = 1'b1;
        prog_req = '0;
        miscompares = 0;
        check_count = 0;
    end

    // Records every word of the boot copy
    always @(posedge clock)
        if (sys_rst)
            copies <= 0;
        else if (sram_wr.we === 1'b1)
        begin
            copies <= copies + 1;
            seen[sram_wr.addr] <= sram_wr.data;
        end

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic port_wr(input logic [23:0] res, input logic [31:0] v);
        @(posedge clock);
        prog_req <= '{wr: 1'b1, res_id: res, data: v};
    endtask

    // Address, data, control back to back; answer may land one or two edges later
    task automatic prog(input logic [15:0] a, input logic [31:0] v, input logic [31:0] ctrl, input logic ok);
        logic done, refd;
        port_wr(RES_OTP_ADDR, {16'h0000, a});
        port_wr(RES_OTP_DATA, v);
        port_wr(RES_OTP_CTRL, ctrl);
        @(posedge clock);
        prog_req.wr <= 1'b0;
        #1 done = prog_done;
        refd = prog_refused;
        @(posedge clock);
        #1 done = done | prog_done;
        refd = refd | prog_refused;
        chk("prog_done", {63'h0, ok}, {63'h0, done});
        chk("prog_refused", {63'h0, !ok}, {63'h0, refd});
    endtask

    task automatic do_reset;
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (8) @(posedge clock);
        #1 chk("deny in reset", 64'h1, {63'h0, link_access_deny});
        chk("release in reset", 64'h0, {63'h0, core_release});
        @(posedge clock);
        sys_rst <= 1'b0;
    endtask

    task automatic wait_release;
        int n;
        n = 0;
        while (core_release !== 1'b1 && n < 3000)
        begin
            @(posedge clock);
            n++;
        end
        repeat (2) @(posedge clock);
        #1 chk("copy count", 64'd2048, copies);
    endtask

    task automatic t_blank;
        do_reset;
        prog(16'h0003, 32'h1111_1111, 32'h1, 1'b0);
        wait_release;
        chk("blank row", 64'h0, {32'h0, seen[3]});
        chk("blank security", 64'h0, {32'h0, security_config});
        chk("boot flash", 64'h0, {63'h0, boot_from_otp});
        chk("jtag access", 64'h1, {63'h0, jtag_tile_access_en});
        chk("link open", 64'h0, {63'h0, link_access_deny});
        $display("test blank done");
    endtask

    task automatic t_program;
        prog(16'h0003, 32'hA5A5_0001, 32'h1, 1'b1);
        prog(16'h0200, 32'h0000_1234, 32'h1, 1'b1);
        prog(16'h0800, 32'h0000_0001, 32'h1, 1'b0);
        prog(16'h0000, SEC_A, 32'h2, 1'b1);
        do_reset;
        wait_release;
        chk("row 3", 64'hA5A5_0001, {32'h0, seen[3]});
        chk("row 512", 64'h1234, {32'h0, seen[512]});
        chk("security word", {32'h0, SEC_A}, {32'h0, security_config});
        chk("gp field", 64'h0, {57'h0, gp_field});
        prog(16'h0201, 32'h0000_0001, 32'h1, 1'b0);
        prog(16'h0004, 32'h0000_0001, 32'h1, 1'b1);
        $display("test program done");
    endtask

    task automatic t_jtag;
        host_u.reset_tap;
        host_u.scan(1'b0, 64, 64'h0, d);
        chk("idcodes", {BSCAN_ID, CHIP_ID}, d);
        chk("tdo_oe shifts", 64'd64, host_u.oe_hits);
        host_u.scan(1'b1, 8, {56'h0, 4'hF, IR_USERCODE}, d);
        host_u.scan(1'b0, 33, 64'h0, d);
        chk("usercode", {32'h0, SEC_A[31:22], 4'h0, REV}, {32'h0, d[31:0]});
        host_u.scan(1'b1, 8, {56'h0, 4'hF, IR_OTP_ADDR}, d);
        host_u.scan(1'b0, 33, 64'h3, d);
        host_u.scan(1'b1, 8, {56'h0, 4'hF, IR_OTP_WRITE}, d);
        host_u.scan(1'b0, 33, 64'h100, d);
        host_u.scan(1'b1, 8, {56'h0, 4'hF, IR_OTP_READ}, d);
        host_u.scan(1'b0, 33, 64'h0, d);
        chk("jtag row 3", 64'hA5A5_0101, {32'h0, d[31:0]});
        host_u.reset_tap;
        host_u.scan(1'b0, 64, 64'h0, d);
        chk("device_identification after tap reset", {BSCAN_ID, CHIP_ID}, d);
        $display("test jtag done");
    endtask

    task automatic t_locks;
        prog(16'h0000, 32'h5A5A_0000, 32'h1, 1'b1);
        prog(16'h0000, 32'hFFFF_FFFF, 32'h2, 1'b1);
        do_reset;
        wait_release;
        chk("reserved zero", 64'hFFFF_BFA3, {32'h0, security_config});
        chk("gp all", 64'h7F, {57'h0, gp_field});
        chk("boot otp", 64'h1, {63'h0, boot_from_otp});
        chk("redundant", 64'h1, {63'h0, redundant_rows_en});
        chk("link deny", 64'h1, {63'h0, link_access_deny});
        chk("jtag off", 64'h0, {63'h0, jtag_tile_access_en});
        host_u.reset_tap;
        host_u.scan(1'b1, 8, {56'h0, 4'hF, IR_OTP_READ}, d);
        host_u.scan(1'b0, 33, 64'h0, d);
        chk("jtag row 0 blocked", 64'h0, {32'h0, d[31:0]});
        prog(16'h0005, 32'h0000_0001, 32'h1, 1'b0);
        prog(16'h0000, 32'h0000_0001, 32'h2, 1'b0);
        $display("test locks done");
    endtask

    task automatic complete_run;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        t_blank;
        t_program;
        t_jtag;
        t_locks;
        complete_run;
    end

    // Tests need about 14000 clocks; this cuts a hang short
    initial
    begin
        repeat (60000) @(posedge clock);
        miscompares++;
        complete_run;
    end
endmodule
`default_nettype wire
